// ==== src/mcq_pkg.sv ====
// shared constants and carriers for the rx fifo 1 / tx shared buffer config and status block
// assumes one host clock domain; frame engine and host port live on the same clock
package mcq_pkg;
  localparam logic [7:0] ADDR_RX_BUFFER_BASE = 8'hac;
  localparam logic [7:0] ADDR_RXQ1_CONFIG = 8'hb0;
  localparam logic [7:0] ADDR_RXQ1_STATE = 8'hb4;
  localparam logic [7:0] ADDR_RXQ1_ACK = 8'hb8;
  localparam logic [7:0] ADDR_RX_ELEM_SIZE = 8'hbc;
  localparam logic [7:0] ADDR_TX_LAYOUT = 8'hc0;
  localparam logic [7:0] ADDR_TX_STATE = 8'hc4;
  localparam logic [7:0] ADDR_TX_PENDING = 8'hcc;
  localparam logic [7:0] ADDR_TX_ADD = 8'hd0;
  localparam logic [7:0] ADDR_TX_CANCEL = 8'hd4;
  // field positions
  localparam int F_MODE = 31;
  localparam int F_WM_MSB = 30;
  localparam int F_WM_LSB = 24;
  localparam int F_SIZE_MSB = 22;
  localparam int F_SIZE_LSB = 16;
  localparam int F_SA_MSB = 15;
  localparam int F_SA_LSB = 2;
  localparam int F_DMS_LSB = 30;
  localparam int F_LOST = 25;
  localparam int F_FULL = 24;
  localparam int F_WPTR_LSB = 16;
  localparam int F_RPTR_LSB = 8;
  localparam int F_FILL_LSB = 0;
  localparam int F_ACK_MSB = 5;
  localparam int F_RX_BUFFER_PAYLOAD_SIZE_LSB = 8;
  localparam int F_RXQ1_PAYLOAD_SIZE_LSB = 4;
  localparam int F_RXQ0_PAYLOAD_SIZE_LSB = 0;
  localparam int F_TQM = 30;
  localparam int F_TQS_MSB = 29;
  localparam int F_TQS_LSB = 24;
  localparam int F_TX_DEDICATED_BUFFER_COUNT_MSB = 21;
  localparam int F_TX_DEDICATED_BUFFER_COUNT_LSB = 16;
  localparam int F_TQF = 21;
  localparam int F_TPUT_LSB = 16;
  localparam int F_TGET_LSB = 8;
  localparam int F_TFREE_LSB = 0;
  // limits and element layout
  localparam logic [6:0] RXQ_MAX = 7'h40;
  localparam logic [5:0] TXQ_MAX = 6'h20;
  localparam logic [4:0] ELEM_HDR_WORDS = 5'h02;
  typedef enum logic [1:0] {DBG_IDLE, DBG_A, DBG_AB, DBG_ABC} mcq_dbg_state_t;
  localparam logic [1:0] DBG_KIND_A = 2'h0;
  localparam logic [1:0] DBG_KIND_B = 2'h1;
  localparam logic [1:0] DBG_KIND_C = 2'h2;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } mcq_bus_req_t;
  typedef struct packed {
    logic valid;
    logic [6:0] frame_bytes;
  } mcq_rx_store_t;
  typedef struct packed {
    logic [5:0] index;
    logic [13:0] word_addr;
    logic [6:0] stored_bytes;
  } mcq_rx_slot_t;
  function automatic logic [6:0] mcq_payload_bytes(input logic [2:0] code);
    case (code)
      3'h0: return 7'h08;
      3'h1: return 7'h0c;
      3'h2: return 7'h10;
      3'h3: return 7'h14;
      3'h4: return 7'h18;
      3'h5: return 7'h20;
      3'h6: return 7'h30;
      default: return 7'h40;
    endcase
  endfunction : mcq_payload_bytes
endpackage : mcq_pkg

// ==== src/mcq_buffer_cfg.sv ====
// rx fifo 1, debug message, element size and tx shared buffer configuration and status
// assumes host port and frame engine share mclk; frame engine obeys accept and pending outputs
`timescale 1ns/1ps
module mcq_buffer_cfg #(
  parameter int TX_BUFS = 32
) (
  input wire logic mclk,
  input wire logic srst,
  input wire mcq_pkg::mcq_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  input wire logic cfg_change_en,
  input wire mcq_pkg::mcq_rx_store_t rxq1_store,
  output logic rxq1_store_accept,
  output mcq_pkg::mcq_rx_slot_t rxq1_slot,
  output logic rxq1_lost_irq_flag,
  input wire logic rxq1_lost_irq_clear,
  output logic rxq1_watermark_irq_flag,
  input wire logic dbg_msg_valid,
  input wire logic [1:0] dbg_msg_kind,
  input wire logic dbg_dma_done,
  output logic dbg_dma_req,
  output logic [13:0] rx_buffer_base_word_addr,
  output logic [6:0] rx_buffer_payload_bytes,
  output logic [6:0] rxq0_payload_bytes,
  input wire logic tx_scan_busy,
  input wire logic tx_done_valid,
  input wire logic [4:0] tx_done_index,
  output logic [TX_BUFS-1:0] tx_pending_set,
  output logic [13:0] tx_section_base_word_addr,
  output logic [5:0] tx_dedicated_count,
  output logic [5:0] tx_shared_count,
  output logic tx_shared_queue_mode
);
  logic rxq1_overwrite_mode;
  logic [6:0] rxq1_watermark_level;
  logic [6:0] rxq1_size_field;
  logic [13:0] rxq1_base_word_addr;
  logic [2:0] rx_buffer_payload_size;
  logic [2:0] rxq1_payload_size;
  logic [2:0] rxq0_payload_size;
  logic [5:0] tx_shared_size_field;
  logic [5:0] tx_dedicated_size_field;
  logic [5:0] rxq1_write_ptr;
  logic [5:0] rxq1_read_ptr;
  logic [6:0] rxq1_fill_level;
  logic [5:0] rxq1_ack_index;
  logic rxq1_lost_flag;
  mcq_pkg::mcq_dbg_state_t dbg_state;
  logic [TX_BUFS-1:0] tx_add_hold;
  logic [4:0] tx_fifo_get_rel;

  // protected writes only while configuration change is allowed
  logic wr_prot;
  assign wr_prot = bus_req.wr && cfg_change_en;

  // effective sizes
  logic [6:0] rxq1_size;
  logic [6:0] rxq1_bytes;
  logic rxq1_full_flag;
  assign rxq1_size = (rxq1_size_field > mcq_pkg::RXQ_MAX) ? mcq_pkg::RXQ_MAX : rxq1_size_field;
  assign rxq1_full_flag = (rxq1_size != 7'h00) && (rxq1_fill_level == rxq1_size);
  assign rxq1_bytes = mcq_pkg::mcq_payload_bytes(rxq1_payload_size);
  assign rx_buffer_payload_bytes = mcq_pkg::mcq_payload_bytes(rx_buffer_payload_size);
  assign rxq0_payload_bytes = mcq_pkg::mcq_payload_bytes(rxq0_payload_size);
  assign tx_dedicated_count = (tx_dedicated_size_field > mcq_pkg::TXQ_MAX) ?
    mcq_pkg::TXQ_MAX : tx_dedicated_size_field;
  assign tx_shared_count = (tx_shared_size_field > mcq_pkg::TXQ_MAX) ?
    mcq_pkg::TXQ_MAX : tx_shared_size_field;

  function automatic logic [6:0] wrap_inc(input logic [6:0] p, input logic [6:0] n);
    logic [6:0] q;
    q = p + 7'h01;
    return (q >= n) ? 7'h00 : q;
  endfunction : wrap_inc

  // configuration registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      rxq1_overwrite_mode <= 1'b0;
      rxq1_watermark_level <= 7'h00;
      rxq1_size_field <= 7'h00;
      rxq1_base_word_addr <= 14'h0000;
      rx_buffer_base_word_addr <= 14'h0000;
      rx_buffer_payload_size <= 3'h0;
      rxq1_payload_size <= 3'h0;
      rxq0_payload_size <= 3'h0;
      tx_shared_queue_mode <= 1'b0;
      tx_shared_size_field <= 6'h00;
      tx_dedicated_size_field <= 6'h00;
      tx_section_base_word_addr <= 14'h0000;
    end else if (wr_prot) begin
      case (bus_req.addr)
        mcq_pkg::ADDR_RXQ1_CONFIG: begin
          rxq1_overwrite_mode <= bus_req.wdata[mcq_pkg::F_MODE];
          rxq1_watermark_level <= bus_req.wdata[mcq_pkg::F_WM_MSB:mcq_pkg::F_WM_LSB];
          rxq1_size_field <= bus_req.wdata[mcq_pkg::F_SIZE_MSB:mcq_pkg::F_SIZE_LSB];
          rxq1_base_word_addr <= bus_req.wdata[mcq_pkg::F_SA_MSB:mcq_pkg::F_SA_LSB];
        end
        mcq_pkg::ADDR_RX_BUFFER_BASE: begin
          rx_buffer_base_word_addr <= bus_req.wdata[mcq_pkg::F_SA_MSB:mcq_pkg::F_SA_LSB];
        end
        mcq_pkg::ADDR_RX_ELEM_SIZE: begin
          rx_buffer_payload_size <= bus_req.wdata[mcq_pkg::F_RX_BUFFER_PAYLOAD_SIZE_LSB+:3];
          rxq1_payload_size <= bus_req.wdata[mcq_pkg::F_RXQ1_PAYLOAD_SIZE_LSB+:3];
          rxq0_payload_size <= bus_req.wdata[mcq_pkg::F_RXQ0_PAYLOAD_SIZE_LSB+:3];
        end
        mcq_pkg::ADDR_TX_LAYOUT: begin
          tx_shared_queue_mode <= bus_req.wdata[mcq_pkg::F_TQM];
          tx_shared_size_field <= bus_req.wdata[mcq_pkg::F_TQS_MSB:mcq_pkg::F_TQS_LSB];
          tx_dedicated_size_field <= bus_req.wdata[mcq_pkg::F_TX_DEDICATED_BUFFER_COUNT_MSB:mcq_pkg::F_TX_DEDICATED_BUFFER_COUNT_LSB];
          tx_section_base_word_addr <= bus_req.wdata[mcq_pkg::F_SA_MSB:mcq_pkg::F_SA_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  // rx fifo 1 bookkeeping
  logic store_ok;
  logic store_drop_oldest;
  logic ack_wr;
  logic [6:0] ack_dist;
  logic [6:0] ack_consumed;
  logic [7:0] next_fill;
  assign ack_wr = bus_req.wr && (bus_req.addr == mcq_pkg::ADDR_RXQ1_ACK);
  // blocking mode refuses a store into a full fifo; overwrite mode takes it
  assign store_ok = rxq1_store.valid && (rxq1_size != 7'h00) &&
    (!rxq1_full_flag || rxq1_overwrite_mode);
  assign store_drop_oldest = store_ok && rxq1_full_flag && !ack_wr;

  always_comb begin
    logic [6:0] ack7;
    logic [6:0] rd7;
    ack7 = {1'b0, bus_req.wdata[mcq_pkg::F_ACK_MSB:0]};
    rd7 = {1'b0, rxq1_read_ptr};
    ack_dist = (ack7 >= rd7) ? (ack7 - rd7) : (ack7 + rxq1_size - rd7);
    ack_consumed = ack_wr ? (ack_dist + 7'h01) : 7'h00;
    // an ack beyond the stored elements only empties the fifo
    if (ack_consumed > rxq1_fill_level) begin
      ack_consumed = rxq1_fill_level;
    end
    next_fill = {1'b0, rxq1_fill_level} + {7'h00, store_ok} - {7'h00, store_drop_oldest} - {1'b0, ack_consumed};
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rxq1_write_ptr <= 6'h00;
      rxq1_read_ptr <= 6'h00;
      rxq1_fill_level <= 7'h00;
      rxq1_ack_index <= 6'h00;
    end else begin
      if (store_ok) begin
        rxq1_write_ptr <= 6'(wrap_inc({1'b0, rxq1_write_ptr}, rxq1_size));
      end
      if (ack_wr) begin
        rxq1_ack_index <= bus_req.wdata[mcq_pkg::F_ACK_MSB:0];
        rxq1_read_ptr <= 6'(wrap_inc({1'b0, bus_req.wdata[mcq_pkg::F_ACK_MSB:0]}, rxq1_size));
      end else if (store_drop_oldest) begin
        rxq1_read_ptr <= 6'(wrap_inc({1'b0, rxq1_read_ptr}, rxq1_size));
      end
      rxq1_fill_level <= next_fill[6:0];
    end
  end

  // lost flag: a set in the clearing cycle wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      rxq1_lost_flag <= 1'b0;
    end else if (rxq1_store.valid && !store_ok) begin
      rxq1_lost_flag <= 1'b1;
    end else if (rxq1_lost_irq_clear) begin
      rxq1_lost_flag <= 1'b0;
    end
  end
  assign rxq1_lost_irq_flag = rxq1_lost_flag;

  // watermark event on the edge of reaching the level
  logic wm_active;
  assign wm_active = (rxq1_watermark_level != 7'h00) && (rxq1_watermark_level <= mcq_pkg::RXQ_MAX);
  always_ff @(posedge mclk) begin
    if (srst) begin
      rxq1_watermark_irq_flag <= 1'b0;
    end else begin
      rxq1_watermark_irq_flag <= wm_active && (next_fill[6:0] >= rxq1_watermark_level) &&
        (rxq1_fill_level < rxq1_watermark_level);
    end
  end

  // slot handed to the frame engine, payload cut to the element size
  localparam logic [4:0] ELEM_HDR_WORDS_F = mcq_pkg::ELEM_HDR_WORDS;
  logic [4:0] elem_words;
  logic [10:0] slot_offset;
  assign elem_words = ELEM_HDR_WORDS_F + rxq1_bytes[6:2];
  // widened first so the product keeps all eleven bits
  assign slot_offset = {5'h00, rxq1_write_ptr} * {6'h00, elem_words};
  always_ff @(posedge mclk) begin
    if (srst) begin
      rxq1_store_accept <= 1'b0;
      rxq1_slot <= '0;
    end else begin
      rxq1_store_accept <= store_ok;
      if (store_ok) begin
        rxq1_slot.index <= rxq1_write_ptr;
        rxq1_slot.word_addr <= rxq1_base_word_addr + {3'h0, slot_offset};
        rxq1_slot.stored_bytes <= (rxq1_store.frame_bytes > rxq1_bytes) ?
          rxq1_bytes : rxq1_store.frame_bytes;
      end
    end
  end

  // debug message sequence a, b, c; dma done returns to idle
  always_ff @(posedge mclk) begin
    if (srst) begin
      dbg_state <= mcq_pkg::DBG_IDLE;
    end else begin
      case (dbg_state)
        mcq_pkg::DBG_IDLE: if (dbg_msg_valid && dbg_msg_kind == mcq_pkg::DBG_KIND_A) dbg_state <= mcq_pkg::DBG_A;
        mcq_pkg::DBG_A: if (dbg_msg_valid && dbg_msg_kind == mcq_pkg::DBG_KIND_B) dbg_state <= mcq_pkg::DBG_AB;
        mcq_pkg::DBG_AB: if (dbg_msg_valid && dbg_msg_kind == mcq_pkg::DBG_KIND_C) dbg_state <= mcq_pkg::DBG_ABC;
        mcq_pkg::DBG_ABC: if (dbg_dma_done) dbg_state <= mcq_pkg::DBG_IDLE;
        default: dbg_state <= mcq_pkg::DBG_IDLE;
      endcase
    end
  end
  logic [1:0] debug_msg_progress;
  always_comb begin
    case (dbg_state)
      mcq_pkg::DBG_A: debug_msg_progress = 2'h1;
      mcq_pkg::DBG_AB: debug_msg_progress = 2'h2;
      mcq_pkg::DBG_ABC: debug_msg_progress = 2'h3;
      default: debug_msg_progress = 2'h0;
    endcase
  end
  assign dbg_dma_req = (dbg_state == mcq_pkg::DBG_ABC);

  // tx pending set; adds during a scan wait for its end
  logic [6:0] tx_total;
  logic [TX_BUFS-1:0] tx_cfg_mask;
  logic [TX_BUFS-1:0] tx_shared_mask;
  logic [TX_BUFS-1:0] tx_add_bits;
  logic [TX_BUFS-1:0] next_pending;
  logic [6:0] tx_busy_cnt;
  logic [4:0] tx_queue_free_rel;
  // no check of the sum; only the clamp to the port width
  assign tx_total = ({1'b0, tx_dedicated_count} + {1'b0, tx_shared_count} > {1'b0, mcq_pkg::TXQ_MAX}) ?
    {1'b0, mcq_pkg::TXQ_MAX} : ({1'b0, tx_dedicated_count} + {1'b0, tx_shared_count});
  always_comb begin
    tx_busy_cnt = 7'h00;
    tx_queue_free_rel = 5'h00;
    for (int i = TX_BUFS - 1; i >= 0; i--) begin
      tx_cfg_mask[i] = (7'(i) < tx_total);
      tx_shared_mask[i] = tx_cfg_mask[i] && (7'(i) >= {1'b0, tx_dedicated_count});
      if (tx_shared_mask[i] && tx_pending_set[i]) tx_busy_cnt = tx_busy_cnt + 7'h01;
      if (tx_shared_mask[i] && !tx_pending_set[i]) tx_queue_free_rel = 5'(7'(i) - {1'b0, tx_dedicated_count});
    end
    tx_add_bits = (bus_req.wr && bus_req.addr == mcq_pkg::ADDR_TX_ADD) ?
      (bus_req.wdata[TX_BUFS-1:0] & tx_cfg_mask) : '0;
    next_pending = tx_pending_set;
    if (tx_done_valid) next_pending[tx_done_index] = 1'b0;
    if (bus_req.wr && bus_req.addr == mcq_pkg::ADDR_TX_CANCEL) begin
      next_pending = next_pending & ~bus_req.wdata[TX_BUFS-1:0];
    end
    if (!tx_scan_busy) next_pending = next_pending | ((tx_add_bits | tx_add_hold) & ~tx_pending_set);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_pending_set <= '0;
      tx_add_hold <= '0;
    end else begin
      tx_pending_set <= next_pending;
      tx_add_hold <= tx_scan_busy ? (tx_add_hold | tx_add_bits) : '0;
    end
  end

  // fifo get pointer follows the head buffer leaving the pending set
  logic [4:0] tx_get_abs;
  assign tx_get_abs = 5'(tx_fifo_get_rel + tx_dedicated_count[4:0]);
  always_ff @(posedge mclk) begin
    if (srst || (wr_prot && bus_req.addr == mcq_pkg::ADDR_TX_LAYOUT)) begin
      tx_fifo_get_rel <= 5'h00;
    end else if (!tx_shared_queue_mode && tx_pending_set[tx_get_abs] && !next_pending[tx_get_abs]) begin
      tx_fifo_get_rel <= 5'(wrap_inc({2'h0, tx_fifo_get_rel}, {1'b0, tx_shared_count}));
    end
  end

  logic tx_shared_full_flag;
  logic [4:0] tx_shared_put_ptr;
  logic [4:0] tx_fifo_get_ptr;
  logic [5:0] tx_fifo_free_level;
  logic [6:0] put_sum;
  assign tx_shared_full_flag = (tx_busy_cnt >= {1'b0, tx_shared_count});
  assign put_sum = {2'h0, tx_fifo_get_rel} + tx_busy_cnt;
  always_comb begin
    logic [4:0] put_rel;
    put_rel = tx_shared_queue_mode ? tx_queue_free_rel :
      ((put_sum >= {1'b0, tx_shared_count}) ? 5'(put_sum - {1'b0, tx_shared_count}) : put_sum[4:0]);
    tx_shared_put_ptr = 5'(put_rel + tx_dedicated_count[4:0]);
    tx_fifo_get_ptr = tx_shared_queue_mode ? 5'h00 : tx_get_abs;
    tx_fifo_free_level = tx_shared_queue_mode ? 6'h00 : 6'(tx_shared_count - tx_busy_cnt[5:0]);
  end

  // register read, answered one cycle after the strobe
  logic [31:0] rd_value;
  always_comb begin
    rd_value = 32'h0000_0000;
    case (bus_req.addr)
      mcq_pkg::ADDR_RX_BUFFER_BASE: rd_value[mcq_pkg::F_SA_MSB:mcq_pkg::F_SA_LSB] = rx_buffer_base_word_addr;
      mcq_pkg::ADDR_RXQ1_CONFIG: begin
        rd_value[mcq_pkg::F_MODE] = rxq1_overwrite_mode;
        rd_value[mcq_pkg::F_WM_MSB:mcq_pkg::F_WM_LSB] = rxq1_watermark_level;
        rd_value[mcq_pkg::F_SIZE_MSB:mcq_pkg::F_SIZE_LSB] = rxq1_size_field;
        rd_value[mcq_pkg::F_SA_MSB:mcq_pkg::F_SA_LSB] = rxq1_base_word_addr;
      end
      mcq_pkg::ADDR_RXQ1_STATE: begin
        rd_value[mcq_pkg::F_DMS_LSB+:2] = debug_msg_progress;
        rd_value[mcq_pkg::F_LOST] = rxq1_lost_flag;
        rd_value[mcq_pkg::F_FULL] = rxq1_full_flag;
        rd_value[mcq_pkg::F_WPTR_LSB+:6] = rxq1_write_ptr;
        rd_value[mcq_pkg::F_RPTR_LSB+:6] = rxq1_read_ptr;
        rd_value[mcq_pkg::F_FILL_LSB+:7] = rxq1_fill_level;
      end
      mcq_pkg::ADDR_RXQ1_ACK: rd_value[mcq_pkg::F_ACK_MSB:0] = rxq1_ack_index;
      mcq_pkg::ADDR_RX_ELEM_SIZE: begin
        rd_value[mcq_pkg::F_RX_BUFFER_PAYLOAD_SIZE_LSB+:3] = rx_buffer_payload_size;
        rd_value[mcq_pkg::F_RXQ1_PAYLOAD_SIZE_LSB+:3] = rxq1_payload_size;
        rd_value[mcq_pkg::F_RXQ0_PAYLOAD_SIZE_LSB+:3] = rxq0_payload_size;
      end
      mcq_pkg::ADDR_TX_LAYOUT: begin
        rd_value[mcq_pkg::F_TQM] = tx_shared_queue_mode;
        rd_value[mcq_pkg::F_TQS_MSB:mcq_pkg::F_TQS_LSB] = tx_shared_size_field;
        rd_value[mcq_pkg::F_TX_DEDICATED_BUFFER_COUNT_MSB:mcq_pkg::F_TX_DEDICATED_BUFFER_COUNT_LSB] = tx_dedicated_size_field;
        rd_value[mcq_pkg::F_SA_MSB:mcq_pkg::F_SA_LSB] = tx_section_base_word_addr;
      end
      mcq_pkg::ADDR_TX_STATE: begin
        rd_value[mcq_pkg::F_TQF] = tx_shared_full_flag;
        rd_value[mcq_pkg::F_TPUT_LSB+:5] = tx_shared_put_ptr;
        rd_value[mcq_pkg::F_TGET_LSB+:5] = tx_fifo_get_ptr;
        rd_value[mcq_pkg::F_TFREE_LSB+:6] = tx_fifo_free_level;
      end
      mcq_pkg::ADDR_TX_PENDING: rd_value[TX_BUFS-1:0] = tx_pending_set;
      default: rd_value = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      bus_rdata <= 32'h0000_0000;
    end else begin
      bus_rdata <= bus_req.rd ? rd_value : 32'h0000_0000;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_ack_write;
    bus_req.wr && bus_req.addr == mcq_pkg::ADDR_RXQ1_ACK && rxq1_size != 7'h00;
  endsequence
  sequence s_dbg_abc;
    dbg_state == mcq_pkg::DBG_AB && dbg_msg_valid && dbg_msg_kind == mcq_pkg::DBG_KIND_C;
  endsequence
  a_blocking_full_lost: assert property (rxq1_store.valid && rxq1_full_flag && !rxq1_overwrite_mode
    |=> rxq1_lost_flag && !rxq1_store_accept) else $error("blocking store into full fifo not lost");
  a_overwrite_no_lost: assert property (rxq1_store.valid && rxq1_full_flag && rxq1_overwrite_mode &&
    !rxq1_lost_flag |=> !rxq1_lost_flag && rxq1_store_accept) else $error("overwrite set lost");
  a_zero_size_lost: assert property (rxq1_store.valid && rxq1_size == 7'h00
    |=> rxq1_lost_flag) else $error("zero size store not flagged");
  a_ack_moves_get: assert property (s_ack_write |=>
    {1'b0, rxq1_read_ptr} == wrap_inc({1'b0, $past(bus_req.wdata[5:0])}, rxq1_size))
    else $error("ack did not move get pointer");
  a_fill_bounded: assert property (rxq1_fill_level <= rxq1_size && rxq1_size <= mcq_pkg::RXQ_MAX)
    else $error("fill level out of range");
  a_dbg_dma_set: assert property (s_dbg_abc |=> dbg_dma_req ##0 debug_msg_progress == 2'h3)
    else $error("dma request not raised after c");
  a_store_truncate: assert property (store_ok |=> rxq1_store_accept &&
    rxq1_slot.stored_bytes <= $past(rxq1_bytes)) else $error("payload not truncated");
  a_queue_reads_zero: assert property (bus_req.rd && bus_req.addr == mcq_pkg::ADDR_TX_STATE &&
    tx_shared_queue_mode |=> bus_rdata[12:8] == 5'h00 && bus_rdata[5:0] == 6'h00)
    else $error("queue mode get or free not zero");
  a_protected_hold: assert property (bus_req.wr && !cfg_change_en && bus_req.addr == mcq_pkg::ADDR_TX_LAYOUT
    |=> $stable(tx_shared_size_field) && $stable(tx_shared_queue_mode)) else $error("protected write taken");
  a_tx_clamp: assert property (tx_shared_count <= mcq_pkg::TXQ_MAX && tx_dedicated_count <= mcq_pkg::TXQ_MAX)
    else $error("tx count not clamped");
endmodule : mcq_buffer_cfg

// ==== dv/mcq_engine_model.sv ====
// frame engine stand-in: fifo 1 stores, debug events, tx completions
// assumes one caller at a time on mclk
`timescale 1ns/1ps
module mcq_engine_model (
  input wire logic mclk,
  output mcq_pkg::mcq_rx_store_t store,
  output logic dbg_valid,
  output logic [1:0] dbg_kind,
  output logic dma_done,
  output logic done_valid,
  output logic [4:0] done_index
);
  initial {store, dbg_valid, dbg_kind, dma_done, done_valid, done_index} = '0;
  // sel 0 store, 1 debug, 2 dma done, 3 tx done; one-cycle strobes
  task automatic pulse(input logic [1:0] sel, input logic [6:0] arg);
    @(posedge mclk);
    store <= {sel == 2'h0, arg};
    dbg_valid <= sel == 2'h1;
    dbg_kind <= arg[1:0];
    dma_done <= sel == 2'h2;
    done_valid <= sel == 2'h3;
    done_index <= arg[4:0];
    @(posedge mclk);
    // stale data inverted so it never passes for a held value
    {store, dbg_valid, dma_done, done_valid} <= {1'b0, ~arg, 3'h0};
    {dbg_kind, done_index} <= ~{arg[1:0], arg[4:0]};
  endtask : pulse
endmodule : mcq_engine_model

// ==== dv/msg_ram_fifo_queue_config_status_tb_top.sv ====
// bench for mcq_buffer_cfg: register port, fifo 1 stores, debug and tx status
// assumes mcq_engine_model as frame engine on the same clock
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module msg_ram_fifo_queue_config_status_tb_top;
  logic mclk, srst, cfg_change_en, lost_clr, dv, dd, tv, acc, lost, dma, wm, busy, qm;
  mcq_pkg::mcq_bus_req_t req;
  mcq_pkg::mcq_rx_store_t store;
  mcq_pkg::mcq_rx_slot_t slot;
  logic [31:0] rdata, d, pend;
  logic [13:0] base, rbase, tbase;
  logic [1:0] dk;
  logic [4:0] ti;
  logic [6:0] rbb, r0b;
  logic [5:0] dcnt, scnt;
  int miscompares = 0;
  int check_count = 0;
  int fill = 0, wp = 0, rp = 0;
  int sz[8] = '{8, 12, 16, 20, 24, 32, 48, 64};
  mcq_buffer_cfg #(.TX_BUFS(32)) DUT (.mclk(mclk), .srst(srst), .bus_req(req), .bus_rdata(rdata),
    .cfg_change_en(cfg_change_en), .rxq1_store(store), .rxq1_store_accept(acc), .rxq1_slot(slot),
    .rxq1_lost_irq_flag(lost), .rxq1_lost_irq_clear(lost_clr), .rxq1_watermark_irq_flag(wm), .dbg_msg_valid(dv),
    .dbg_msg_kind(dk), .dbg_dma_done(dd), .dbg_dma_req(dma), .rx_buffer_base_word_addr(rbase),
    .rx_buffer_payload_bytes(rbb), .rxq0_payload_bytes(r0b), .tx_scan_busy(busy), .tx_done_valid(tv),
    .tx_done_index(ti), .tx_pending_set(pend), .tx_section_base_word_addr(tbase), .tx_dedicated_count(dcnt),
    .tx_shared_count(scnt), .tx_shared_queue_mode(qm));
  mcq_engine_model eng (.mclk(mclk), .store(store), .dbg_valid(dv), .dbg_kind(dk), .dma_done(dd),
    .done_valid(tv), .done_index(ti));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    req <= {w, !w, a, wd};
    @(posedge mclk);
    req <= {2'b00, a, wd};
    #1 d = rdata;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("rdata", e, d)
  endtask : rchk
  // fifo 1 status from the model, four elements deep
  function automatic logic [31:0] st(input logic l);
    return {6'h0, l, fill == 4, 2'h0, 6'(wp), 2'h0, 6'(rp), 1'h0, 7'(fill)};
  endfunction : st
  task automatic store1(input logic bl);
    eng.pulse(2'h0, 7'h14);
    #1;
    `CHK("accept", !bl, acc)
    `CHK("lost_wm", {bl, fill == 1 && !bl}, {lost, wm})
    if (!bl) begin
      `CHK("slot", {6'(wp), 14'(base + wp * 4), 7'h08}, slot)
      if (fill == 4) rp = (rp + 1) % 4;
      else fill++;
      wp = (wp + 1) % 4;
    end
  endtask : store1
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    miscompares++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h800a));
    {srst, cfg_change_en, lost_clr, busy, req} = {4'b1000, 42'h0};
    base = 14'($urandom);
    repeat (10) @(posedge mclk);
    srst <= 0;
    rchk(mcq_pkg::ADDR_RXQ1_STATE, 32'h0);
    rchk(mcq_pkg::ADDR_TX_STATE, 32'h0020_0000);
    eng.pulse(2'h0, 7'h08);
    #1 `CHK("zero_size", 2'b01, {acc, lost})
    @(posedge mclk) lost_clr <= 1;
    @(posedge mclk) lost_clr <= 0;
    bus(1'b1, mcq_pkg::ADDR_RXQ1_CONFIG, {16'h0204, base, 2'h0});
    rchk(mcq_pkg::ADDR_RXQ1_CONFIG, 32'h0);
    bus(1'b1, mcq_pkg::ADDR_TX_LAYOUT, 32'h7f3f_fffc);
    rchk(mcq_pkg::ADDR_TX_LAYOUT, 32'h0);
    @(posedge mclk) cfg_change_en <= 1;
    bus(1'b1, mcq_pkg::ADDR_RXQ1_CONFIG, {16'h0204, base, 2'h0});
    rchk(mcq_pkg::ADDR_RXQ1_CONFIG, {16'h0204, base, 2'h0});
    bus(1'b1, mcq_pkg::ADDR_RX_BUFFER_BASE, {16'h0, ~base, 2'h0});
    `CHK("rbase", ~base, rbase)
    for (int c = 7; c >= 0; c--) begin
      bus(1'b1, mcq_pkg::ADDR_RX_ELEM_SIZE, {21'h0, 3'(c), 5'h0, 3'(c)});
      `CHK("sizes", {2{7'(sz[c])}}, {rbb, r0b})
    end
    for (int i = 0; i < 5; i++) store1(i == 4);
    rchk(mcq_pkg::ADDR_RXQ1_STATE, st(1));
    bus(1'b1, mcq_pkg::ADDR_RXQ1_ACK, 32'h1);
    {rp, fill} = {32'd2, 32'd2};
    rchk(mcq_pkg::ADDR_RXQ1_STATE, st(1));
    bus(1'b1, mcq_pkg::ADDR_RXQ1_CONFIG, {16'h8204, base, 2'h0});
    @(posedge mclk) lost_clr <= 1;
    @(posedge mclk) lost_clr <= 0;
    for (int i = 0; i < 3; i++) store1(1'b0);
    rchk(mcq_pkg::ADDR_RXQ1_STATE, st(0));
    for (int k = 0; k < 3; k++) eng.pulse(2'h1, 7'(k));
    #1 `CHK("dma", 1'b1, dma)
    rchk(mcq_pkg::ADDR_RXQ1_STATE, st(0) | 32'hc000_0000);
    eng.pulse(2'h2, 7'h0);
    rchk(mcq_pkg::ADDR_RXQ1_STATE, st(0));
    bus(1'b1, mcq_pkg::ADDR_TX_LAYOUT, 32'h2821_0000);
    `CHK("counts", 12'h820, {dcnt, scnt})
    bus(1'b1, mcq_pkg::ADDR_TX_LAYOUT, {16'h0302, base, 2'h0});
    bus(1'b1, mcq_pkg::ADDR_TX_ADD, 32'hffff_ffff);
    `CHK("pending", 32'h1f, pend)
    rchk(mcq_pkg::ADDR_TX_STATE, 32'h0022_0200);
    eng.pulse(2'h3, 7'h02);
    bus(1'b0, mcq_pkg::ADDR_TX_STATE, 32'h0);
    `CHK("txstate", {32'h1b, 6'h02, 5'h03}, {pend, d[21:16], d[12:8]})
    bus(1'b1, mcq_pkg::ADDR_TX_CANCEL, 32'h1);
    `CHK("cancel", 32'h1a, pend)
    @(posedge mclk) busy <= 1;
    bus(1'b1, mcq_pkg::ADDR_TX_ADD, 32'h1);
    `CHK("held", 32'h1a, pend)
    @(posedge mclk) busy <= 0;
    @(posedge mclk) #1 `CHK("added", 32'h1b, pend)
    bus(1'b1, mcq_pkg::ADDR_TX_LAYOUT, {16'h4302, base, 2'h0});
    `CHK("txcfg", {1'b1, base}, {qm, tbase})
    bus(1'b0, mcq_pkg::ADDR_TX_STATE, 32'h0);
    `CHK("qmode", 16'h0, d[15:0])
    rchk(8'hf0, 32'h0);
    print_verdict();
  end
endmodule : msg_ram_fifo_queue_config_status_tb_top
